// ===== hw/dps_pkg.sv
// Package for the drive power and retract sequencer.
// Assumes a single 100 MHz clock and synchronous pin inputs.
package dps_pkg;
   // Clock rate and timing
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned SPIN_TIMEOUT_S = 15;
   localparam longint unsigned SPIN_TIMEOUT_CYC =
      longint'(SPIN_TIMEOUT_S) * longint'(CLK_HZ);
   localparam int unsigned TMR_W = 32;
   // Minimum spindle speed, rpm
   localparam logic [15:0] MIN_RPM = 16'h0BB8;
   localparam logic [15:0] RPM_ZERO = 16'h0000;

   // Sequencer states
   typedef enum logic [2:0] {
      DPS_OFF,
      DPS_SPINUP,
      DPS_SEEK,
      DPS_READY,
      DPS_RETRACT
   } dps_state_type;

   // Monitored health inputs, all active high meaning good/ok
   typedef struct packed {
      logic ac_ok;
      logic p24_ok;
      logic p5_ok;
      logic motor_cool;
      logic blower_ok;
      logic breakers_closed;
      logic dc_in_tol;
      logic air_press_ok;
   } dps_health_type;

   // Commands from the controller
   typedef struct packed {
      logic seek;
      logic head_sel;
      logic read;
      logic write;
   } dps_cmd_type;
endpackage

// ===== hw/dps_seq.sv
// Power-up, power-hold and retract sequencer for a fixed disk drive.
// Assumes all pin inputs are synchronous to ref_clk_in; pick and hold
// inputs arrive already inverted to active high (ground = asserted).
`timescale 1ns/1ns

module dps_seq
   import dps_pkg::*;
#(
   parameter longint unsigned SPIN_CYC = SPIN_TIMEOUT_CYC
)
(
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic remote_mode_in,
   input wire logic start_sw_in,
   input wire logic seq_pick_in,
   input wire logic seq_hold_in,
   input wire dps_health_type health_in,
   input wire logic [15:0] spindle_rpm_in,
   input wire logic select_req_in,
   input wire dps_cmd_type cmd_in,
   input wire logic seek_done_in,
   input wire logic heads_home_in,
   input wire logic [7:0] op_status_in,
   output logic motor_on_out,
   output logic brake_release_out,
   output logic retract_out,
   output logic rtz_seek_out,
   output logic seq_pick_out,
   output logic selected_out,
   output logic ready_out,
   output dps_cmd_type cmd_accept_out,
   output logic [7:0] op_status_out,
   output logic status_en_out
);

   dps_state_type state_r;
   dps_state_type state_nxt;
   logic [TMR_W-1:0] tmr_r;
   logic start_prev_r;
   logic selected_r;
   logic [7:0] status_r;
   logic fault;
   logic at_speed;
   logic start_press;
   logic run_req;
   logic power_drop;
   logic powered;
   logic tmr_done;

   // Retract fault gathering; any bad condition forces a retract
   // speed and supply loss
   assign at_speed = spindle_rpm_in >= MIN_RPM;
   // thermal, blower, breaker, DC and air faults
   assign fault = !health_in.ac_ok || !health_in.p24_ok ||
      !health_in.p5_ok || !health_in.motor_cool ||
      !health_in.blower_ok || !health_in.breakers_closed ||
      !health_in.dc_in_tol || !health_in.air_press_ok ||
      ((state_r == DPS_SEEK || state_r == DPS_READY) && !at_speed);

   assign start_press = start_sw_in && !start_prev_r;
   // remote start needs switch on plus pick and hold from controller
   // local mode alone may start without the controller
   assign run_req = remote_mode_in ?
      (start_sw_in && seq_pick_in && seq_hold_in) : start_press;
   // remote power holds while hold grounded and start on
   assign power_drop = remote_mode_in ?
      (!start_sw_in || (!seq_hold_in && !seq_pick_in) || !seq_hold_in)
      : start_press;
   assign tmr_done = tmr_r >= SPIN_CYC[TMR_W-1:0];
   assign powered = state_r == DPS_SEEK || state_r == DPS_READY;

   // Start switch edge detect for local toggling
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         start_prev_r <= 1'b0;
      else
         start_prev_r <= start_sw_in;
   end

   // Next-state logic; a fault wins over every other transition except retract back to off
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         DPS_OFF:
            if (run_req && !fault)
               state_nxt = DPS_SPINUP;
         DPS_SPINUP:
            if (fault || power_drop)
               state_nxt = DPS_RETRACT;
            else if (tmr_done && at_speed)
               state_nxt = DPS_SEEK;
         DPS_SEEK:
            if (fault || power_drop)
               state_nxt = DPS_RETRACT;
            else if (seek_done_in)
               state_nxt = DPS_READY;
         DPS_READY:
            if (fault || power_drop)
               state_nxt = DPS_RETRACT;
         DPS_RETRACT:
            // Wait for heads home and start released before rearming
            if (heads_home_in && !start_sw_in)
               state_nxt = DPS_OFF;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         state_r <= DPS_OFF;
      else
         state_r <= state_nxt;
   end

   // Spin-up timer; saturates so a slow spindle just waits longer
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         tmr_r <= '0;
      else if (state_r != DPS_SPINUP)
         tmr_r <= '0;
      else if (!tmr_done)
         tmr_r <= tmr_r + 1'b1;
   end

   // Motor, brake and head outputs, registered from the next state
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         motor_on_out <= 1'b0;
         brake_release_out <= 1'b0;
         retract_out <= 1'b0;
         rtz_seek_out <= 1'b0;
      end
      else
      begin
         // motor stops and heads retract on retract state
         motor_on_out <= state_nxt inside {DPS_SPINUP, DPS_SEEK,
            DPS_READY};
         brake_release_out <= state_nxt inside {DPS_SPINUP, DPS_SEEK,
            DPS_READY};
         retract_out <= state_nxt == DPS_RETRACT;
         rtz_seek_out <= state_nxt == DPS_SEEK;
      end
   end

   // Daisy-chain pick forwarding, held off until our spindle is up
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         seq_pick_out <= 1'b0;
      else
         seq_pick_out <= seq_pick_in && powered && at_speed && !fault;
   end

   // Unit selection; dropped whenever power goes away
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         selected_r <= 1'b0;
      else
         selected_r <= select_req_in && powered;
   end

   // Ready, accepted commands and status toward the controller
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ready_out <= 1'b0;
         cmd_accept_out <= '0;
         status_r <= 8'h00;
      end
      else
      begin
         // ready only after first seek with no fault
         ready_out <= state_r == DPS_READY && !fault;
         // commands only when selected and ready
         cmd_accept_out <= (selected_r && state_r == DPS_READY && !fault)
            ? cmd_in : '0;
         status_r <= selected_r ? op_status_in : 8'h00;
      end
   end

   assign selected_out = selected_r;
   assign op_status_out = status_r;
   // status lines driven as long as selected
   assign status_en_out = selected_r;

   // Assertions; all gathered here after the logic they guard
   // fault retracts heads
   AST_FAULT_RETRACT: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (fault && powered) |=> retract_out)
      else $error("Fault did not retract heads");
   AST_SPEED_LOSS: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (state_r == DPS_READY && !at_speed)
      |=> retract_out)
      else $error("Speed loss did not retract heads");
   AST_FAULT_MOTOR: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (fault && state_r != DPS_OFF)
      |=> !motor_on_out)
      else $error("Motor still on after fault");
   AST_AIR_RETRACT: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in)
      (!health_in.air_press_ok && state_r == DPS_READY)
      |=> state_r == DPS_RETRACT)
      else $error("Low air pressure ignored");
   AST_BREAKER: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in)
      (!health_in.breakers_closed && state_r == DPS_SPINUP)
      |=> state_r == DPS_RETRACT)
      else $error("Open breaker ignored");
   AST_PICK_FWD: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) seq_pick_out |-> $past(at_speed))
      else $error("Pick forwarded before speed");
   AST_SEL_POWER: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) selected_out |-> $past(powered))
      else $error("Selected without power");
   AST_CMD_READY: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in)
      (cmd_accept_out != '0) |-> $past(state_r) == DPS_READY)
      else $error("Command accepted while not ready");
   AST_STATUS: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in)
      selected_out |=> op_status_out == $past(op_status_in, 1))
      else $error("Status not tracking while selected");
   AST_REMOTE_DROP: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (remote_mode_in && !seq_pick_in &&
      !seq_hold_in && powered) |=> state_r == DPS_RETRACT)
      else $error("Pick and hold release did not power down");
   AST_REMOTE_START: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (state_r == DPS_OFF && remote_mode_in
      && !seq_pick_in) |=> state_r == DPS_OFF)
      else $error("Remote start without pick");
   AST_REMOTE_HOLD: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (state_r == DPS_READY && remote_mode_in &&
      seq_hold_in && start_sw_in && !fault) |=> state_r == DPS_READY)
      else $error("Remote hold did not keep power");
   AST_LOCAL_IDLE: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (state_r == DPS_OFF && !remote_mode_in &&
      !start_press) |=> state_r == DPS_OFF)
      else $error("Local power-on without switch press");
   AST_READY_FAULT: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) ready_out |-> !$past(fault))
      else $error("Ready shown during fault");
   AST_RETRACT_READY: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) state_r == DPS_RETRACT |=> !ready_out)
      else $error("Ready shown during retract");
   AST_SEEK_SPEED: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) (state_r == DPS_SPINUP &&
      state_nxt == DPS_SEEK) |-> at_speed && tmr_done)
      else $error("Seek started early");
   AST_RTZ_START: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) $rose(rtz_seek_out) |->
      $past(tmr_done) && $past(at_speed))
      else $error("Return-to-zero seek started early");

   COV_READY: cover property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) $rose(ready_out));
   COV_RETRACT: cover property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) state_r == DPS_READY ##1 retract_out);
   COV_PICK: cover property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) $rose(seq_pick_out));
   COV_CMD: cover property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) cmd_accept_out.write);
   // Remote power-up seen at least once
   COV_REMOTE_UP: cover property (@(posedge ref_clk_in)
      disable iff (!rst_b_in) remote_mode_in && $rose(motor_on_out));

endmodule

// ===== verification/dps_mech_model.sv
// Spindle and carriage model facing the power sequencer.
// Assumes it shares the sequencer clock and reset.
`timescale 1ns/1ns
module dps_mech_model
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic motor_in,
   input wire logic rtz_in,
   input wire logic retract_in,
   input wire logic stall_in,
   output logic [15:0] rpm_out,
   output logic seek_done_out,
   output logic home_out
);
   logic [3:0] spin_r;
   logic [2:0] seek_r;
   // Spindle needs several cycles to come up to speed
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         spin_r <= 4'h0;
      else if (!motor_in)
         spin_r <= 4'h0;
      else if (spin_r != 4'hF)
         spin_r <= spin_r + 4'h1;
   end
   // Seek takes time, so ready cannot follow the seek state at once
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         seek_r <= 3'h0;
      else if (!rtz_in)
         seek_r <= 3'h0;
      else if (seek_r != 3'h7)
         seek_r <= seek_r + 3'h1;
   end
   // A stall sits one rpm under the minimum, the hardest case
   assign rpm_out = stall_in ? 16'h0BB7 :
                    (spin_r > 4'h4 ? 16'h0BB8 : 16'h0000);
   assign seek_done_out = seek_r == 3'h7;
   assign home_out = retract_in;
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the power and retract sequencer.
// Assumes a short spin-up count; the mechanics come from the model.
`timescale 1ns/1ns
module testbench
   import dps_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic remote, start, pick, hold, stall, sel;
   dps_health_type health;
   dps_cmd_type cmd, acc;
   logic [7:0] ops, st_o;
   logic [15:0] rpm;
   logic done, home, motor, brake, retr, rtz, pick_o, seld, rdy, sten;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   dps_mech_model mech (.clk_in(clk), .rst_b_in(rst_b), .motor_in(motor),
      .rtz_in(rtz), .retract_in(retr), .stall_in(stall), .rpm_out(rpm),
      .seek_done_out(done), .home_out(home));
   dps_seq #(.SPIN_CYC(20)) dut (.ref_clk_in(clk), .rst_b_in(rst_b),
      .remote_mode_in(remote), .start_sw_in(start), .seq_pick_in(pick),
      .seq_hold_in(hold), .health_in(health), .spindle_rpm_in(rpm),
      .select_req_in(sel), .cmd_in(cmd), .seek_done_in(done),
      .heads_home_in(home), .op_status_in(ops), .motor_on_out(motor),
      .brake_release_out(brake), .retract_out(retr), .rtz_seek_out(rtz),
      .seq_pick_out(pick_o), .selected_out(seld), .ready_out(rdy),
      .cmd_accept_out(acc), .op_status_out(st_o), .status_en_out(sten));
   task automatic results;
      $display("comparisons %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         results();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_on(input int k);
      int i;
      for (i = 0; i < 100; i++)
      begin
         if ((k == 0 && rtz === 1'b1) || (k == 1 && rdy === 1'b1))
            break;
         step(1);
      end
      check(i < 100, 1'b1);
   endtask
   task automatic reset;
      rst_b = 1'b0;
      {remote, start, pick, hold, stall, sel} = 6'h00;
      health = 8'hFF;
      cmd = 4'h0;
      ops = 8'h00;
      step(2);
      rst_b = 1'b1;
      step(1);
      check(motor, 1'b0);
   endtask
   task automatic up_local;
      reset();
      start = 1'b1;
      wait_on(1);
   endtask
   task automatic t_local;
      reset();
      sel = 1'b1;
      cmd = 4'hF;
      ops = 8'h5A;
      step(3);
      check(seld, 1'b0);
      check(acc, 4'h0);
      start = 1'b1;
      step(1);
      check({motor, brake}, 2'h3);
      step(15);
      check(rtz, 1'b0);
      wait_on(0);
      step(1);
      check({seld, acc}, 5'h10);
      wait_on(1);
      step(1);
      check(acc, 4'hF);
      check({sten, st_o}, 9'h15A);
      sel = 1'b0;
      step(2);
      check({sten, acc}, 5'h00);
      start = 1'b0;
      step(1);
      start = 1'b1;
      step(1);
      check({retr, motor}, 2'h2);
   endtask
   task automatic t_fault;
      for (int b = 0; b < 8; b++)
      begin
         up_local();
         health[b] = 1'b0;
         step(1);
         check({retr, motor}, 2'h2);
         step(1);
         check(rdy, 1'b0);
      end
      up_local();
      stall = 1'b1;
      step(1);
      check({retr, motor}, 2'h2);
      reset();
      start = 1'b1;
      step(3);
      health = 8'hFE;
      step(1);
      check(retr, 1'b1);
      health = 8'hFF;
      step(40);
      check(rdy, 1'b0);
      // Releasing the switch rearms; a new press must bring ready back
      start = 1'b0;
      step(1);
      check({retr, motor}, 2'h0);
      start = 1'b1;
      step(1);
      check(motor, 1'b1);
      wait_on(1);
   endtask
   task automatic t_remote;
      reset();
      remote = 1'b1;
      start = 1'b1;
      step(3);
      check(motor, 1'b0);
      {pick, hold} = 2'h3;
      step(1);
      check({motor, pick_o}, 2'h2);
      wait_on(1);
      check(pick_o, 1'b1);
      pick = 1'b0;
      step(3);
      check({motor, rdy}, 2'h3);
      hold = 1'b0;
      step(1);
      check({retr, motor}, 2'h2);
      start = 1'b0;
      step(1);
      check(retr, 1'b0);
      // pick and hold again, then switch off in remote
      {pick, hold} = 2'h3;
      start = 1'b1;
      step(1);
      check(motor, 1'b1);
      start = 1'b0;
      step(1);
      check({retr, motor}, 2'h2);
   endtask
   initial
   begin
      t_local();
      t_fault();
      t_remote();
      results();
   end
endmodule
